// ===== common/cpu_state_pkg.sv
`default_nettype none
package cpu_state_pkg;
    // ****************************************
    // register reset values and flag layout
    // ****************************************
    localparam logic [15:0] CODE_SEG_RESET = 16'hffff;
    localparam logic [15:0] DATA_SEG_RESET = 16'h0000;
    localparam logic [15:0] OFFSET_PTR_RESET = 16'h0000;
    localparam logic [15:0] COND_WORD_RESET = 16'h0000;
    localparam logic [15:0] COND_WORD_MASK = 16'h0fd5;
    localparam int OVERFLOW_BIT = 11;
    localparam int DIRECTION_BIT = 10;
    localparam int INT_ENABLE_BIT = 9;
    localparam int TRACE_BIT = 8;
    localparam int SIGN_BIT = 7;
    localparam int ZERO_BIT = 6;
    localparam int NIBBLE_BIT = 4;
    localparam int PARITY_BIT = 2;
    localparam int CARRY_BIT = 0;
    localparam int SEG_SHIFT = 4;
    localparam int ADDR_WIDTH = 20;

    typedef enum logic [1:0] {SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA} seg_sel_type;

    typedef enum logic [3:0] {
        FOP_NONE, FOP_ARITH, FOP_LOGIC, FOP_LOAD, FOP_SET_DIR, FOP_CLR_DIR,
        FOP_SET_INT, FOP_CLR_INT
    } flag_op_type;

    // outcome of one executed instruction as seen by the flags
    typedef struct packed {
        logic [15:0] result;
        logic byte_op;
        logic carry_out;
        logic nibble_carry;
        logic overflow;
    } alu_outcome_type;

    typedef struct packed {
        logic valid;
        logic [2:0] index;
        logic byte_sel;
        logic high_half;
        logic [15:0] data;
    } gpr_write_type;
endpackage : cpu_state_pkg
`default_nettype wire

// ===== verilog/gpr_bank.sv
`default_nettype none
module gpr_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire cpu_state_pkg::gpr_write_type wr,
    input wire logic [2:0] rd_index,
    output logic [15:0] rd_data,
    output logic [7:0] count_low
);
    logic [15:0] regs_r [8];
    logic [15:0] regs_nxt [8];

    // ****************************************
    // eight words, first four split in halves
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_reg
            always_comb begin
                regs_nxt[g] = regs_r[g];
                if (wr.valid && wr.index == 3'(g)) begin
                    if (wr.byte_sel && g < 4) begin
                        if (wr.high_half) begin
                            regs_nxt[g][15:8] = wr.data[7:0];
                        end else begin
                            regs_nxt[g][7:0] = wr.data[7:0];
                        end
                    end else begin
                        regs_nxt[g] = wr.data;
                    end
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_r[g] <= 16'h0000;
                end else begin
                    regs_r[g] <= regs_nxt[g];
                end
            end
        end
    endgenerate

    assign rd_data = regs_r[rd_index];
    assign count_low = regs_r[1][7:0];
endmodule : gpr_bank
`default_nettype wire

// ===== verilog/addr_gen.sv
`default_nettype none
module addr_gen (
    input wire logic [15:0] segment,
    input wire logic [15:0] offset,
    output logic [19:0] phys_addr
);
    // wraps past the top of the 1 MB space
    assign phys_addr = 20'({segment, 4'h0}) + 20'(offset);
endmodule : addr_gen
`default_nettype wire

// ===== verilog/cpu_register_state_flags.sv
`default_nettype none
module cpu_register_state_flags (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_N_IN,
    input wire cpu_state_pkg::gpr_write_type GPR_WR_IN,
    input wire logic [2:0] GPR_RD_INDEX_IN,
    input wire logic SEG_WR_IN,
    input wire cpu_state_pkg::seg_sel_type SEG_WR_SEL_IN,
    input wire logic [15:0] SEG_WR_DATA_IN,
    input wire logic PTR_LOAD_IN,
    input wire logic [15:0] PTR_LOAD_DATA_IN,
    input wire logic PTR_STEP_IN,
    input wire logic [2:0] PTR_STEP_LEN_IN,
    input wire logic INSTR_DONE_IN,
    input wire cpu_state_pkg::flag_op_type FLAG_OP_IN,
    input wire cpu_state_pkg::alu_outcome_type ALU_IN,
    input wire logic [15:0] FLAG_LOAD_DATA_IN,
    input wire logic MASKABLE_REQ_IN,
    input wire cpu_state_pkg::seg_sel_type ADDR_SEG_SEL_IN,
    input wire logic [15:0] ADDR_OFFSET_IN,
    output logic [15:0] GPR_RD_DATA_OUT,
    output logic [7:0] SHIFT_COUNT_OUT,
    output logic [15:0] CODE_SEG_OUT,
    output logic [15:0] DATA_SEG_OUT,
    output logic [15:0] STACK_SEG_OUT,
    output logic [15:0] EXTRA_SEG_OUT,
    output logic [15:0] OFFSET_PTR_OUT,
    output logic [19:0] FETCH_ADDR_OUT,
    output logic [19:0] PHYS_ADDR_OUT,
    output logic [15:0] COND_WORD_OUT,
    output logic STRING_STEP_UP_OUT,
    output logic MASKABLE_ACCEPT_OUT,
    output logic TRACE_TRAP_OUT
);
    logic [15:0] code_seg_r, code_seg_nxt;
    logic [15:0] data_segment_base_r, data_segment_base_nxt;
    logic [15:0] stack_seg_r, stack_seg_nxt;
    logic [15:0] extra_segment_base_r, extra_segment_base_nxt;
    logic [15:0] instruction_offset_pointer_r, instruction_offset_pointer_nxt;
    logic [15:0] cond_r, cond_nxt;
    logic trace_arm_r, trace_arm_nxt;
    logic trap_r, trap_nxt;
    logic [15:0] sel_seg;
    logic [19:0] phys_addr;
    logic [19:0] fetch_addr;
    logic [15:0] res;

    // ****************************************
    // general registers
    // ****************************************
    gpr_bank u_gpr (
        .clk(CORE_CLK_IN),
        .rst_n(RESET_N_IN),
        .wr(GPR_WR_IN),
        .rd_index(GPR_RD_INDEX_IN),
        .rd_data(GPR_RD_DATA_OUT),
        .count_low(SHIFT_COUNT_OUT)
    );

    // ****************************************
    // segment bases and offset pointer
    // ****************************************
    always_comb begin
        code_seg_nxt = code_seg_r;
        data_segment_base_nxt = data_segment_base_r;
        stack_seg_nxt = stack_seg_r;
        extra_segment_base_nxt = extra_segment_base_r;
        instruction_offset_pointer_nxt = instruction_offset_pointer_r;
        if (SEG_WR_IN) begin
            case (SEG_WR_SEL_IN)
                cpu_state_pkg::SEG_CODE: code_seg_nxt = SEG_WR_DATA_IN;
                cpu_state_pkg::SEG_DATA: data_segment_base_nxt = SEG_WR_DATA_IN;
                cpu_state_pkg::SEG_STACK: stack_seg_nxt = SEG_WR_DATA_IN;
                default: extra_segment_base_nxt = SEG_WR_DATA_IN;
            endcase
        end
        // no software port: only jumps and sequential fetch move it
        if (PTR_LOAD_IN) begin
            instruction_offset_pointer_nxt = PTR_LOAD_DATA_IN;
        end else if (PTR_STEP_IN) begin
            instruction_offset_pointer_nxt = instruction_offset_pointer_r
                + {13'h0, PTR_STEP_LEN_IN};
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            code_seg_r <= cpu_state_pkg::CODE_SEG_RESET;
            data_segment_base_r <= cpu_state_pkg::DATA_SEG_RESET;
            stack_seg_r <= cpu_state_pkg::DATA_SEG_RESET;
            extra_segment_base_r <= cpu_state_pkg::DATA_SEG_RESET;
            instruction_offset_pointer_r <= cpu_state_pkg::OFFSET_PTR_RESET;
        end else begin
            code_seg_r <= code_seg_nxt;
            data_segment_base_r <= data_segment_base_nxt;
            stack_seg_r <= stack_seg_nxt;
            extra_segment_base_r <= extra_segment_base_nxt;
            instruction_offset_pointer_r <= instruction_offset_pointer_nxt;
        end
    end

    // ****************************************
    // condition word
    // ****************************************
    always_comb begin
        cond_nxt = cond_r;
        trace_arm_nxt = trace_arm_r;
        trap_nxt = 1'b0;
        res = ALU_IN.result;
        if (INSTR_DONE_IN) begin
            case (FLAG_OP_IN)
                cpu_state_pkg::FOP_ARITH, cpu_state_pkg::FOP_LOGIC: begin
                    if (ALU_IN.byte_op) begin
                        cond_nxt[cpu_state_pkg::SIGN_BIT] = res[7];
                        cond_nxt[cpu_state_pkg::ZERO_BIT] = (res[7:0] == 8'h00);
                    end else begin
                        cond_nxt[cpu_state_pkg::SIGN_BIT] = res[15];
                        cond_nxt[cpu_state_pkg::ZERO_BIT] = (res == 16'h0000);
                    end
                    cond_nxt[cpu_state_pkg::PARITY_BIT] = ~(^res[7:0]);
                    if (FLAG_OP_IN == cpu_state_pkg::FOP_ARITH) begin
                        cond_nxt[cpu_state_pkg::OVERFLOW_BIT] = ALU_IN.overflow;
                        cond_nxt[cpu_state_pkg::NIBBLE_BIT] = ALU_IN.nibble_carry;
                        cond_nxt[cpu_state_pkg::CARRY_BIT] = ALU_IN.carry_out;
                    end else begin
                        // logical operations leave no carry or overflow
                        cond_nxt[cpu_state_pkg::OVERFLOW_BIT] = 1'b0;
                        cond_nxt[cpu_state_pkg::CARRY_BIT] = 1'b0;
                    end
                end
                cpu_state_pkg::FOP_LOAD: begin
                    cond_nxt = FLAG_LOAD_DATA_IN & cpu_state_pkg::COND_WORD_MASK;
                end
                cpu_state_pkg::FOP_SET_DIR: cond_nxt[cpu_state_pkg::DIRECTION_BIT] = 1'b1;
                cpu_state_pkg::FOP_CLR_DIR: cond_nxt[cpu_state_pkg::DIRECTION_BIT] = 1'b0;
                cpu_state_pkg::FOP_SET_INT: cond_nxt[cpu_state_pkg::INT_ENABLE_BIT] = 1'b1;
                cpu_state_pkg::FOP_CLR_INT: cond_nxt[cpu_state_pkg::INT_ENABLE_BIT] = 1'b0;
                default: cond_nxt = cond_r;
            endcase
            // trap after the instruction that follows the trace-setting load
            if (trace_arm_r && cond_r[cpu_state_pkg::TRACE_BIT]) begin
                trap_nxt = 1'b1;
            end
            if (FLAG_OP_IN == cpu_state_pkg::FOP_LOAD) begin
                trace_arm_nxt = FLAG_LOAD_DATA_IN[cpu_state_pkg::TRACE_BIT];
            end else if (!cond_r[cpu_state_pkg::TRACE_BIT]) begin
                trace_arm_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            cond_r <= cpu_state_pkg::COND_WORD_RESET;
            trace_arm_r <= 1'b0;
            trap_r <= 1'b0;
        end else begin
            cond_r <= cond_nxt;
            trace_arm_r <= trace_arm_nxt;
            trap_r <= trap_nxt;
        end
    end

    // ****************************************
    // address generation
    // ****************************************
    always_comb begin
        case (ADDR_SEG_SEL_IN)
            cpu_state_pkg::SEG_CODE: sel_seg = code_seg_r;
            cpu_state_pkg::SEG_DATA: sel_seg = data_segment_base_r;
            cpu_state_pkg::SEG_STACK: sel_seg = stack_seg_r;
            default: sel_seg = extra_segment_base_r;
        endcase
    end

    addr_gen u_addr (
        .segment(sel_seg),
        .offset(ADDR_OFFSET_IN),
        .phys_addr(phys_addr)
    );

    addr_gen u_fetch (
        .segment(code_seg_r),
        .offset(instruction_offset_pointer_r),
        .phys_addr(fetch_addr)
    );

    assign PHYS_ADDR_OUT = phys_addr;
    assign FETCH_ADDR_OUT = fetch_addr;
    assign CODE_SEG_OUT = code_seg_r;
    assign DATA_SEG_OUT = data_segment_base_r;
    assign STACK_SEG_OUT = stack_seg_r;
    assign EXTRA_SEG_OUT = extra_segment_base_r;
    assign OFFSET_PTR_OUT = instruction_offset_pointer_r;
    assign COND_WORD_OUT = cond_r & cpu_state_pkg::COND_WORD_MASK;
    assign STRING_STEP_UP_OUT = cond_r[cpu_state_pkg::DIRECTION_BIT];
    assign MASKABLE_ACCEPT_OUT = MASKABLE_REQ_IN
        & cond_r[cpu_state_pkg::INT_ENABLE_BIT];
    assign TRACE_TRAP_OUT = trap_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    a_reserved_zero: assert property (
        (COND_WORD_OUT & ~cpu_state_pkg::COND_WORD_MASK) == 16'h0000)
        else $error("reserved flag bit set");
    a_zero_flag: assert property (
        INSTR_DONE_IN && FLAG_OP_IN == cpu_state_pkg::FOP_ARITH && !ALU_IN.byte_op
        |=> COND_WORD_OUT[6] == ($past(ALU_IN.result) == 16'h0000))
        else $error("zero flag wrong");
    a_sign_flag: assert property (
        INSTR_DONE_IN && FLAG_OP_IN == cpu_state_pkg::FOP_ARITH && !ALU_IN.byte_op
        |=> COND_WORD_OUT[7] == $past(ALU_IN.result[15]))
        else $error("sign flag wrong");
    a_parity_flag: assert property (
        INSTR_DONE_IN && FLAG_OP_IN == cpu_state_pkg::FOP_LOGIC
        |=> COND_WORD_OUT[2] == ~(^$past(ALU_IN.result[7:0])))
        else $error("parity flag wrong");
    a_carry_flag: assert property (
        INSTR_DONE_IN && FLAG_OP_IN == cpu_state_pkg::FOP_ARITH
        |=> COND_WORD_OUT[0] == $past(ALU_IN.carry_out)
            && COND_WORD_OUT[11] == $past(ALU_IN.overflow)
            && COND_WORD_OUT[4] == $past(ALU_IN.nibble_carry))
        else $error("carry, overflow or nibble flag wrong");
    a_dir_control: assert property (
        INSTR_DONE_IN && FLAG_OP_IN == cpu_state_pkg::FOP_SET_DIR |=> STRING_STEP_UP_OUT)
        else $error("direction flag not set");
    a_dir_clear: assert property (
        INSTR_DONE_IN && FLAG_OP_IN == cpu_state_pkg::FOP_CLR_DIR |=> !STRING_STEP_UP_OUT)
        else $error("direction flag not cleared");
    a_int_gate: assert property (!COND_WORD_OUT[9] |-> !MASKABLE_ACCEPT_OUT)
        else $error("request passed while disabled");
    // upper sixteen bits checked as a wrapping add, low nibble passes straight through
    a_phys_addr: assert property (
        PHYS_ADDR_OUT[3:0] == ADDR_OFFSET_IN[3:0]
        && PHYS_ADDR_OUT[19:4] == sel_seg + {4'h0, ADDR_OFFSET_IN[15:4]})
        else $error("physical address wrong");
    a_trace_trap: assert property (
        INSTR_DONE_IN && FLAG_OP_IN == cpu_state_pkg::FOP_LOAD && FLAG_LOAD_DATA_IN[8]
        ##1 INSTR_DONE_IN |=> TRACE_TRAP_OUT)
        else $error("no trap after traced instruction");
    a_fetch_hold: assert property (
        !PTR_LOAD_IN && !PTR_STEP_IN |=> $stable(OFFSET_PTR_OUT))
        else $error("offset pointer moved");

    c_trap: cover property (TRACE_TRAP_OUT);
    c_carry: cover property (COND_WORD_OUT[0] && COND_WORD_OUT[11]);
    c_accept: cover property (MASKABLE_ACCEPT_OUT);
endmodule : cpu_register_state_flags
`default_nettype wire

// ===== test/biu_model.sv
`default_nettype none
module biu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fetch_req,
    input wire logic [2:0] fetch_len,
    input wire logic slow,
    output logic step,
    output logic [2:0] step_len
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy_r;
    logic [1:0] wait_r;
    logic [2:0] len_r;
    // offset pointer moves only when a fetch retires
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            wait_r <= 2'h0;
            len_r <= 3'h0;
            step <= 1'b0;
        end else begin
            step <= 1'b0;
            if (fetch_req) begin
                busy_r <= 1'b1;
                len_r <= fetch_len;
                wait_r <= slow ? 2'h3 : 2'h0;
            end else if (busy_r && wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end else if (busy_r) begin
                busy_r <= 1'b0;
                step <= 1'b1;
            end
        end
    end
    // length is only valid with the strobe, so hide stale values
    assign step_len = step ? len_r : ~len_r;
endmodule : biu_model
`default_nettype wire

// ===== test/tb_cpu_register_state_flags.sv
`default_nettype none
module tb_cpu_register_state_flags;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cpu_state_pkg::gpr_write_type gwr = '0;
    logic [2:0] grd = 3'h0;
    logic seg_wr = 1'b0;
    cpu_state_pkg::seg_sel_type ssel = cpu_state_pkg::SEG_EXTRA;
    cpu_state_pkg::seg_sel_type asel = cpu_state_pkg::SEG_EXTRA;
    logic [15:0] sdat = 16'h0000;
    logic [15:0] ipd = 16'h0000;
    logic [15:0] fld = 16'h0000;
    logic [15:0] aofs = 16'h0000;
    logic ipl = 1'b0;
    logic done = 1'b0;
    logic mreq = 1'b0;
    logic freq = 1'b0;
    logic slow = 1'b0;
    logic [2:0] flen = 3'h1;
    cpu_state_pkg::flag_op_type fop = cpu_state_pkg::FOP_NONE;
    cpu_state_pkg::alu_outcome_type alu = '0;
    logic ptr_step, up, acc, trap;
    logic [2:0] ptr_len;
    logic [7:0] shc;
    logic [15:0] gq, cs, dsg, ss, esg, ipq, cw;
    logic [19:0] fa, pa;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [15:0] rnd = 16'hdd23;
    logic [15:0] gm [8];
    logic [15:0] sm [4];
    logic [15:0] ipm, cwm;
    always #2.5 clk = ~clk;
    cpu_register_state_flags cpu_register_state_flags_i (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
        .GPR_WR_IN(gwr), .GPR_RD_INDEX_IN(grd), .SEG_WR_IN(seg_wr), .SEG_WR_SEL_IN(ssel),
        .SEG_WR_DATA_IN(sdat), .PTR_LOAD_IN(ipl), .PTR_LOAD_DATA_IN(ipd),
        .PTR_STEP_IN(ptr_step), .PTR_STEP_LEN_IN(ptr_len), .INSTR_DONE_IN(done),
        .FLAG_OP_IN(fop), .ALU_IN(alu),
        .FLAG_LOAD_DATA_IN(fld), .MASKABLE_REQ_IN(mreq), .ADDR_SEG_SEL_IN(asel),
        .ADDR_OFFSET_IN(aofs), .GPR_RD_DATA_OUT(gq), .SHIFT_COUNT_OUT(shc), .CODE_SEG_OUT(cs),
        .DATA_SEG_OUT(dsg), .STACK_SEG_OUT(ss), .EXTRA_SEG_OUT(esg), .OFFSET_PTR_OUT(ipq),
        .FETCH_ADDR_OUT(fa), .PHYS_ADDR_OUT(pa), .COND_WORD_OUT(cw), .STRING_STEP_UP_OUT(up),
        .MASKABLE_ACCEPT_OUT(acc), .TRACE_TRAP_OUT(trap));
    biu_model biu_model_i (.clk(clk), .rst_n(rst_n), .fetch_req(freq), .fetch_len(flen),
        .slow(slow), .step(ptr_step), .step_len(ptr_len));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic tick();
        @(posedge clk);
        #1;
        rnd = lfsr(rnd);
    endtask : tick
    task automatic finish_test();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask : chk
    task automatic chk_state();
        chk("code_seg", {4'h0, sm[1]}, {4'h0, cs});
        chk("data_seg", {4'h0, sm[3]}, {4'h0, dsg});
        chk("stack_seg", {4'h0, sm[2]}, {4'h0, ss});
        chk("extra_seg", {4'h0, sm[0]}, {4'h0, esg});
        chk("offset_ptr", {4'h0, ipm}, {4'h0, ipq});
        chk("fetch", ({4'h0, sm[1]} << 4) + {4'h0, ipm}, fa);
        chk("cond", {4'h0, cwm}, {4'h0, cw});
    endtask : chk_state
    task automatic model_reset();
        sm = '{16'h0000, 16'hffff, 16'h0000, 16'h0000};
        ipm = 16'h0000;
        cwm = 16'h0000;
        foreach (gm[i]) gm[i] = 16'h0000;
    endtask : model_reset
    task automatic flag_step();
        logic a;
        a = (fop == cpu_state_pkg::FOP_ARITH);
        tick();
        case (fop)
            cpu_state_pkg::FOP_ARITH, cpu_state_pkg::FOP_LOGIC: begin
                cwm[11] = a & alu.overflow;
                cwm[0] = a & alu.carry_out;
                cwm[4] = a ? alu.nibble_carry : cwm[4];
                cwm[7] = alu.byte_op ? alu.result[7] : alu.result[15];
                cwm[6] = alu.byte_op ? (alu.result[7:0] == 8'h00) : (alu.result == 16'h0000);
                cwm[2] = ~^alu.result[7:0];
            end
            cpu_state_pkg::FOP_LOAD: cwm = fld & 16'h0fd5;
            cpu_state_pkg::FOP_SET_DIR: cwm[10] = 1'b1;
            cpu_state_pkg::FOP_CLR_DIR: cwm[10] = 1'b0;
            cpu_state_pkg::FOP_SET_INT: cwm[9] = 1'b1;
            cpu_state_pkg::FOP_CLR_INT: cwm[9] = 1'b0;
            default: cwm = cwm;
        endcase
        chk("cond", {4'h0, cwm}, {4'h0, cw});
        chk("step_up", {19'h0, cwm[10]}, {19'h0, up});
        chk("accept", {19'h0, mreq & cwm[9]}, {19'h0, acc});
    endtask : flag_step
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        model_reset();
        repeat (8) tick();
        chk_state();
        rst_n = 1'b1;
        gwr.valid = 1'b1;
        for (int k = 0; k < 24; k++) begin
            gwr.index = 3'(k % 8);
            gwr.byte_sel = (k >= 8);
            gwr.high_half = (k >= 16);
            gwr.data = (k >= 8 && k % 8 < 4) ? {rnd[7:0], rnd[7:0]} : rnd;
            grd = gwr.index;
            if (k < 8 || k % 8 >= 4) gm[k % 8] = gwr.data;
            else if (k >= 16) gm[k % 8][15:8] = gwr.data[7:0];
            else gm[k % 8][7:0] = gwr.data[7:0];
            tick();
            chk("gpr", {4'h0, gm[grd]}, {4'h0, gq});
            chk("shift_count", {12'h0, gm[1][7:0]}, {12'h0, shc});
        end
        gwr.valid = 1'b0;
        seg_wr = 1'b1;
        for (int s = 0; s < 4; s++) begin
            ssel = cpu_state_pkg::seg_sel_type'(s);
            sdat = rnd;
            sm[s] = rnd;
            tick();
        end
        seg_wr = 1'b0;
        chk_state();
        for (int n = 0; n < 16; n++) begin
            asel = cpu_state_pkg::seg_sel_type'(n % 4);
            aofs = (n < 4) ? 16'hffff : rnd;
            #1;
            chk("phys", ({4'h0, sm[n % 4]} << 4) + {4'h0, aofs}, pa);
            tick();
        end
        ipl = 1'b1;
        ipd = rnd;
        ipm = rnd;
        tick();
        ipl = 1'b0;
        for (int n = 0; n < 4; n++) begin
            slow = n[0];
            freq = 1'b1;
            flen = rnd[2:0];
            ipm = ipm + {13'h0, rnd[2:0]};
            tick();
            freq = 1'b0;
            for (int w = 0; w < 8 && !ptr_step; w++) tick();
            tick();
            chk_state();
        end
        done = 1'b1;
        for (int n = 0; n < 64; n++) begin
            fop = cpu_state_pkg::flag_op_type'(rnd[2:0]);
            alu = {(rnd[11:8] == 4'h0) ? 16'h0000 : lfsr(rnd), rnd[15:12]};
            fld = lfsr(lfsr(rnd));
            mreq = rnd[5];
            flag_step();
        end
        fop = cpu_state_pkg::FOP_LOAD;
        fld = 16'h0000;
        flag_step();
        fld = 16'hffff;
        flag_step();
        chk("trap_on_load", 20'h0, {19'h0, trap});
        fop = cpu_state_pkg::FOP_ARITH;
        flag_step();
        chk("trap_next", 20'h1, {19'h0, trap});
        flag_step();
        chk("trap_again", 20'h1, {19'h0, trap});
        done = 1'b0;
        tick();
        chk("trap_idle", 20'h0, {19'h0, trap});
        rst_n = 1'b0;
        model_reset();
        #1;
        chk_state();
        finish_test();
    end
endmodule : tb_cpu_register_state_flags
`default_nettype wire
